// ==== rtl/sacc_map.svh ====
// Register offsets, field positions, reset values and timing counts
// of the conversion controller. Definitions only, no logic.
`ifndef SACC_MAP_SVH
`define SACC_MAP_SVH

// Byte offsets of the register words (haddr[7:0])
`define SACC_OFS_CTRL 8'h00
`define SACC_OFS_TIME 8'h04
`define SACC_OFS_CMD  8'h08
`define SACC_OFS_STAT 8'h0C
`define SACC_OFS_RES  8'h10
`define SACC_OFS_TEMP 8'h14

// Field positions
`define SACC_CTRL_CH_LSB    0
`define SACC_CTRL_MODE_LSB  8
`define SACC_CTRL_TSTRB_BIT 12
`define SACC_TIME_DIV_LSB   0
`define SACC_TIME_STC_LSB   8
`define SACC_CMD_START_BIT  0
`define SACC_TEMP_CORR_LSB  16

// Reset values
`define SACC_CH_RST   5'h00
`define SACC_MODE_RST 4'h0
`define SACC_DIV_RST  8'h00
`define SACC_STC_RST  8'h00

// Timing counts in conversion clock periods; temperature offset in kelvin
`define SACC_SAMPLE_BASE 9'h002
`define SACC_CAL_TICKS   2'h2
`define SACC_TEMP_OFS_K  10'h005

`endif

// ==== rtl/sacc_pkg.sv ====
// Types shared by the conversion controller files.
// Assumes sacc_map.svh supplies the numeric constants.
package sacc_pkg;

  // Resolution codes, in mode bit [1:0] order
  typedef enum logic [1:0] {SACC_RES_10, SACC_RES_12, SACC_RES_8, SACC_RES_NA} sacc_res_t;

  // Conversion phases
  typedef enum logic [1:0] {SACC_IDLE, SACC_SAMPLE, SACC_DIST, SACC_CAL} sacc_phase_t;

  // Kind of source behind a multiplexer channel
  typedef enum logic [2:0] {
    SACC_SRC_CORE, SACC_SRC_VOLT, SACC_SRC_CURR, SACC_SRC_QTEMP, SACC_SRC_DIE
  } sacc_src_t;

  // Whole state of the controller
  typedef struct packed {
    logic [4:0]  ch;      // Channel select
    logic [3:0]  mode;    // Mode bits
    logic        tstrb;   // Internal temperature strobe level
    logic [7:0]  div;     // Conversion clock divider
    logic [7:0]  sample_time_count;     // Sample time count
    sacc_phase_t ph;      // Conversion phase
    logic [8:0]  cnt;     // Ticks within phase
    logic [11:0] sar;     // Approximation register
    logic [3:0]  bidx;    // Bit under trial
    sacc_res_t   res;     // Resolution latched at start
    logic        cal_en;  // Post calibration latched at start
    logic [7:0]  stc_l;   // Sample count latched at start
    logic [11:0] result;  // Held result
    logic        valid;   // Result valid
    logic        cmp_m;   // Comparator sync stage 1
    logic        cmp_q;   // Comparator sync stage 2
    logic        a_vld;   // Bus data phase pending
    logic        a_wr;    // Pending phase is a write
    logic [7:0]  a_addr;  // Pending address
    logic [31:0] rdata;   // Read data for data phase
  } sacc_st_t;

endpackage

// ==== rtl/sacc_clkdiv.sv ====
// Conversion clock enable: a one-cycle tick every 4*(1+divider) clocks.
// Assumes restart comes from logic on the same clock.
`timescale 1ns/100ps
module sacc_clkdiv #(
  parameter int DIV_W = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             restart,
  input  wire logic [DIV_W-1:0] divider,
  output logic                  tick
);

  typedef struct packed {
    logic [DIV_W+1:0] cnt;  // Clocks since last tick
  } sacc_div_st_t;

  sacc_div_st_t s_r;   // Registered state
  sacc_div_st_t s_nxt; // Next state

  // Terminal count is 4*(1+divider)-1; restart re-aligns the phase
  assign tick = (s_r.cnt == {divider, 2'h3}) && !restart;

  // Next state
  always_comb begin
    s_nxt = s_r;
    if (restart || tick) begin
      s_nxt.cnt = '0;
    end else begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Ticks never come closer than four clocks
  AST_DIV_GAP: assert property (@(posedge clk) disable iff (!rst_n)
    tick |=> !tick [*3])
    else $error("conversion tick period below four clocks");

endmodule

// ==== rtl/sacc_ctrl.sv ====
// Conversion controller of a 12-bit SAR converter with a 32:1 input mux.
// Assumes an AHB-Lite master on clk and an analog comparator on cmp_hi.
`timescale 1ns/100ps
`include "sacc_map.svh"

// Overview of operation
// - Channel select is plain binary 0 to 31
// - Channel 0 core supply, 31 die temperature
// - Channels 1+3q, 2+3q, 3+3q per quad
// - Mode bits 1:0 pick 10, 12, 8 bits
// - Mode bit 3 low adds two calibration ticks
// - Mode bit 2 low powers down when idle
// - Result MSB-justified, unused low bits zero
// - Conversion clock period 4*(1+divider) clocks
// - Start sampled on rising system clock edge
// - Busy and sampling rise at sample start
// - Sample phase lasts 2+count conversion clocks
// - Phases: sample, distribution, optional calibration
// - 10-bit temperature count equals kelvin
// - 8-bit temperature is 4 kelvin steps
// - Readings carry +5 degree offset, removable
// - Distribution one tick per bit, sampling falls
// - Valid rises as busy falls
// - Valid holds until next start, result held
module sacc_ctrl (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic               hresp,
  output logic [31:0]        hrdata,
  input  wire logic          cmp_hi,
  output logic [4:0]         mux_channel,
  output sacc_pkg::sacc_src_t mux_src,
  output logic [3:0]         mux_quad,
  output logic [11:0]        dac_code,
  output logic               internal_temp_strobe,
  output logic               adc_power_on,
  output logic               busy,
  output logic               sampling,
  output logic               cal_active,
  output logic               result_valid,
  output logic [11:0]        result,
  output logic [9:0]         temp_kelvin
);
  import sacc_pkg::*;

  // Whole controller state lives in one struct; n is its next value.
  // Everything else here, bar the u_div counter and the check tick counters, is combinational and settles within a cycle.
  sacc_st_t    s;         // Registered state
  sacc_st_t    n;         // Next state
  logic        tick;      // Conversion clock enable
  logic        start_w;   // Start bit written this cycle
  logic        start_acc; // Start taken
  logic        finish;    // Conversion ends this cycle
  logic [11:0] sar_f;     // Approximation after this tick
  logic        in_dist;   // Distribution phase flag
  logic [6:0]  ch_dec;    // Decoded source kind and quad number

  // Lowest bit resolved for a resolution; the rest stay zero
  // Code 11 is not to be used; running it as 10-bit keeps results defined
  function automatic logic [3:0] res_lsb(input sacc_res_t r);
    case (r)
      SACC_RES_12: res_lsb = 4'h0;
      SACC_RES_8:  res_lsb = 4'h4;
      default:     res_lsb = 4'h2; // Unused code runs as 10-bit
    endcase
  endfunction

  // Channel to source kind and quad number
  function automatic logic [6:0] chan_decode(input logic [4:0] ch);
    logic [4:0] idx;
    logic [4:0] q;
    logic [4:0] k;
    idx = ch - 5'h01;
    q = idx / 5'h03;
    k = idx % 5'h03;
    // Channels 0 and 31 are wired inside, whatever quads are fitted
    if (ch == 5'h00) begin
      chan_decode = {SACC_SRC_CORE, 4'h0};
    end else if (ch == 5'h1F) begin
      chan_decode = {SACC_SRC_DIE, 4'h0};
    end else begin
      chan_decode = {3'(k + 5'h01), q[3:0]};
    end
  endfunction

  // Read data is staged at the address edge from the registered state,
  // so a read right behind a write to the same word returns the old
  // value; masters leave one idle cycle between the two.
  // Register read mux; kelvin view is result bits 11:2 in every mode
  function automatic logic [31:0] rd_mux(input sacc_st_t st, input logic [7:0] a);
    logic [9:0] kel;
    logic [9:0] corr;
    kel = st.result[11:2];
    corr = (kel >= `SACC_TEMP_OFS_K) ? kel - `SACC_TEMP_OFS_K : 10'h000;
    rd_mux = 32'h0000_0000;
    case (a)
      `SACC_OFS_CTRL: rd_mux = {19'h00000, st.tstrb, st.mode, 3'h0, st.ch};
      `SACC_OFS_TIME: rd_mux = {16'h0000, st.sample_time_count, st.div};
      `SACC_OFS_STAT: rd_mux = {28'h0000000, st.ph == SACC_CAL, st.valid,
                                st.ph == SACC_SAMPLE, st.ph != SACC_IDLE};
      `SACC_OFS_RES:  rd_mux = {20'h00000, st.result};
      `SACC_OFS_TEMP: rd_mux = {6'h00, corr, 6'h00, kel};
      default:        rd_mux = 32'h0000_0000; // Unmapped reads zero
    endcase
  endfunction

  // A free-running divider would shorten the first sample tick by up to
  // a whole period; restarting it keeps every phase length exact
  // Conversion clock enable, phase-aligned to each accepted start
  sacc_clkdiv #(
    .DIV_W(8)
  ) u_div (
    .clk    (clk),
    .rst_n  (rst_n),
    .restart(start_acc),
    .divider(s.div),
    .tick   (tick)
  );

  // Next-state logic: bus slave, sequencer and approximation
  always_comb begin
    n = s;
    start_w = 1'b0;
    start_acc = 1'b0;
    finish = 1'b0;
    sar_f = s.sar;
    // Comparator crosses from the analog side
    // Only the second stage is read by the decision logic
    n.cmp_m = cmp_hi;
    n.cmp_q = s.cmp_m;
    // Divider and channel act live: software keeps them still while busy
    // Write data phase
    if (s.a_vld && s.a_wr) begin
      case (s.a_addr)
        `SACC_OFS_CTRL: begin
          n.ch = hwdata[`SACC_CTRL_CH_LSB +: 5];
          n.mode = hwdata[`SACC_CTRL_MODE_LSB +: 4];
          n.tstrb = hwdata[`SACC_CTRL_TSTRB_BIT];
        end
        `SACC_OFS_TIME: begin
          n.div = hwdata[`SACC_TIME_DIV_LSB +: 8];
          n.sample_time_count = hwdata[`SACC_TIME_STC_LSB +: 8];
        end
        `SACC_OFS_CMD: start_w = hwdata[`SACC_CMD_START_BIT];
        default: ; // Unmapped writes are dropped
      endcase
    end
    // A refused start leaves no trace on the bus; software polls busy first
    // Starts during a conversion are ignored
    start_acc = start_w && (s.ph == SACC_IDLE);
    case (s.ph)
      // Idle: wait for a start and latch the settings
      SACC_IDLE: begin
        if (start_acc) begin
          n.ph = SACC_SAMPLE;
          n.cnt = 9'h000;
          n.valid = 1'b0;
          n.res = sacc_res_t'(s.mode[1:0]);
          n.cal_en = ~s.mode[3];
          n.stc_l = s.sample_time_count;
        end
      end
      // Sample: 2+count ticks, then first bit trial
      // cnt holds the ticks already spent in this phase
      SACC_SAMPLE: begin
        if (tick) begin
          if (s.cnt == {1'b0, s.stc_l} + `SACC_SAMPLE_BASE - 9'h001) begin
            n.ph = SACC_DIST;
            n.sar = 12'h800;
            n.bidx = 4'hB;
          end else begin
            n.cnt = s.cnt + 9'h001;
          end
        end
      end
      // Distribution: one bit decided per tick
      SACC_DIST: begin
        if (tick) begin
          // Input below the trial code: the trial bit is dropped
          if (!s.cmp_q) begin
            sar_f[s.bidx] = 1'b0;
          end
          if (s.bidx == res_lsb(s.res)) begin
            if (s.cal_en) begin
              n.ph = SACC_CAL;
              n.cnt = 9'h000;
            end else begin
              finish = 1'b1;
            end
          end else begin
            // Next lower bit goes on trial
            n.bidx = s.bidx - 4'h1;
            sar_f[s.bidx - 4'h1] = 1'b1;
          end
          n.sar = sar_f;
        end
      end
      // Calibration: fixed tick count, busy held
      // Busy stays high here, so valid cannot rise before calibration ends
      SACC_CAL: begin
        if (tick) begin
          if (s.cnt == {7'h00, `SACC_CAL_TICKS} - 9'h001) begin
            finish = 1'b1;
          end else begin
            n.cnt = s.cnt + 9'h001;
          end
        end
      end
      default: n.ph = SACC_IDLE;
    endcase
    // End of conversion: busy drops, valid rises, result latched
    // From calibration, sar_f still holds the word of the last bit trial
    if (finish) begin
      n.ph = SACC_IDLE;
      n.valid = 1'b1;
      n.result = sar_f;
    end
    // Address phase; read data is staged so hrdata comes from a flop
    // hsize is not decoded: only whole-word accesses are supported
    n.a_vld = hsel && hready && htrans[1];
    n.a_wr = hwrite;
    n.a_addr = haddr[7:0];
    n.rdata = rd_mux(s, haddr[7:0]);
  end

  // State register, synchronous reset
  // The comparator flops clear too, so no stale decision outlives reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
      s.ch <= `SACC_CH_RST;
      s.mode <= `SACC_MODE_RST;
      s.div <= `SACC_DIV_RST;
      s.sample_time_count <= `SACC_STC_RST;
    end else begin
      s <= n;
    end
  end

  // Outputs
  // Busy, sampling and cal flags decode the phase, so they all move on the same edge
  assign hreadyout = 1'b1;     // Zero wait states
  assign hresp = 1'b0;         // Always OKAY
  assign hrdata = s.rdata;
  assign mux_channel = s.ch;
  // Enum field is cast out of the decode word on purpose
  assign ch_dec = chan_decode(s.ch);
  assign mux_src = sacc_src_t'(ch_dec[6:4]);
  assign mux_quad = ch_dec[3:0];
  assign dac_code = s.sar;
  assign internal_temp_strobe = s.tstrb;
  assign adc_power_on = (s.ph != SACC_IDLE) || s.mode[2];
  assign busy = s.ph != SACC_IDLE;
  assign sampling = s.ph == SACC_SAMPLE;
  assign cal_active = s.ph == SACC_CAL;
  assign result_valid = s.valid;
  assign result = s.result;
  assign temp_kelvin = s.result[11:2];
  assign in_dist = s.ph == SACC_DIST;

  // Tick counts per phase, seen only by the checks below
  // They restart on every accepted start, so a check at the end of a
  // phase sees the ticks of the running conversion only
  logic [8:0] hs_cnt; // Sample ticks
  logic [3:0] hd_cnt; // Distribution ticks
  logic [1:0] hc_cnt; // Calibration ticks

  always_ff @(posedge clk) begin
    if (!rst_n || start_acc) begin
      hs_cnt <= 9'h000;
      hd_cnt <= 4'h0;
      hc_cnt <= 2'h0;
    end else if (tick) begin
      if (sampling) begin
        hs_cnt <= hs_cnt + 9'h001;
      end
      if (in_dist) begin
        hd_cnt <= hd_cnt + 4'h1;
      end
      if (cal_active) begin
        hc_cnt <= hc_cnt + 2'h1;
      end
    end
  end

  // All checks run on clk and rest while reset is low
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_START_RISE: assert property (start_acc |=> busy && sampling && !result_valid)
    else $error("start did not raise busy and sampling");
  AST_SAMPLE_LEN: assert property ($fell(sampling) |->
    busy && hs_cnt == {1'b0, s.stc_l} + `SACC_SAMPLE_BASE)
    else $error("sample phase length wrong");
  AST_DIST_LEN: assert property ($fell(in_dist) |-> hd_cnt == 4'hC - res_lsb(s.res))
    else $error("distribution length wrong");
  AST_CAL_LEN: assert property ($fell(cal_active) |-> hc_cnt == 2'h2 && result_valid)
    else $error("calibration length wrong");
  AST_NO_CAL: assert property ($fell(busy) && !s.cal_en |-> hc_cnt == 2'h0)
    else $error("calibration ran while disabled");
  AST_VALID_ON_FALL: assert property ($fell(busy) |-> result_valid && $rose(result_valid))
    else $error("valid did not rise with busy fall");
  AST_VALID_HOLD: assert property (result_valid && !start_acc |=>
    result_valid && $stable(result))
    else $error("valid or result changed before start");
  AST_LOW_ZERO: assert property (result_valid |->
    (s.res != SACC_RES_8 || result[3:0] == 4'h0) &&
    (s.res == SACC_RES_8 || s.res == SACC_RES_12 || result[1:0] == 2'h0))
    else $error("unused result bits not zero");
  AST_PWR: assert property (!adc_power_on |-> !busy && !s.mode[2])
    else $error("power state wrong");
  AST_FIXED: assert property ((mux_channel == 5'h00 |-> mux_src == SACC_SRC_CORE) and
    (mux_channel == 5'h1F |-> mux_src == SACC_SRC_DIE))
    else $error("fixed channel source wrong");
  AST_QUAD: assert property (mux_channel inside {[5'h01:5'h1E]} |->
    {1'b0, mux_quad} * 5'h03 + {2'h0, mux_src} == mux_channel)
    else $error("quad channel mapping wrong");
  AST_DIST_ENTRY: assert property ($fell(sampling) |->
    in_dist && dac_code == 12'h800)
    else $error("distribution did not start at the top bit");
  AST_RESULT_STILL: assert property (busy && !finish |=> $stable(result))
    else $error("result moved during a conversion");

  // Scenarios the bench is expected to reach
  COV_8BIT: cover property (finish && s.res == SACC_RES_8);
  COV_NOCAL: cover property ($fell(busy) && !s.cal_en);
  COV_REFUSED: cover property (start_w && busy);
  COV_DIE: cover property (start_acc && s.ch == 5'h1F);
  COV_CAL: cover property ($fell(cal_active));

endmodule

// ==== sim/sacc_ana_model.sv ====
// Analog front end behind the controller: per-channel levels and comparator.
// Assumes mux_channel and dac_code come from sacc_ctrl on the same clock.
`timescale 1ns/100ps
module sacc_ana_model (
  input  wire logic        clk,
  input  wire logic [4:0]  mux_channel,
  input  wire logic [11:0] dac_code,
  input  wire logic        internal_temp_strobe,
  input  wire logic        adc_power_on,
  output logic             cmp_hi
);
  logic [11:0] lvl;        // Input level in full-scale codes
  logic        tog = 1'b0; // Junk output of an unpowered comparator

  // Channel code to level, plain binary decode
  always_comb begin
    if (mux_channel == 5'h00) begin
      lvl = 12'h960; // Core supply
    end else if (mux_channel == 5'h1F) begin
      // Die diode reads 298 K only while strobed
      lvl = internal_temp_strobe ? 12'h4A8 : 12'h000;
    end else begin
      lvl = {mux_channel, 7'h35}; // Distinct level per quad input
    end
  end

  // Toggles so a powered-down comparator never passes by luck
  always @(posedge clk) begin
    tog <= ~tog;
  end

  // High while the input is at or above the trial code
  assign cmp_hi = adc_power_on ? (lvl >= dac_code) : tog;
endmodule

// ==== sim/sacc_ctrl_tb.sv ====
// Self-checking bench of sacc_ctrl: AHB-Lite master, conversion table,
// then refused start, register access and mid-run reset.
// Assumes sacc_ana_model answers the comparator.
`timescale 1ns/100ps
`include "sacc_map.svh"
module sacc_ctrl_tb;
  import sacc_pkg::*;

  typedef struct {
    logic [3:0]  mode; // Mode bits
    logic [4:0]  ch;   // Channel
    logic [7:0]  div;  // Clock divider
    logic [7:0]  sample_time_count;  // Sample count
    logic [11:0] exp;  // Expected result
  } sacc_row_t;

  logic        clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        cmp_hi;
  logic [4:0]  mux_channel;
  sacc_src_t   mux_src;
  logic [3:0]  mux_quad;
  logic [11:0] dac_code;
  logic        internal_temp_strobe;
  logic        adc_power_on;
  logic        busy;
  logic        sampling;
  logic        cal_active;
  logic        result_valid;
  logic [11:0] result;
  logic [9:0]  temp_kelvin;
  logic [31:0] rd_smp;      // hrdata as seen at the edge
  logic [31:0] q;           // Read data of last transfer
  int          mismatches = 0;
  int          checks_done = 0;
  int          cyc = 0;     // Watchdog count
  int          i, nb, ns, nc, p, nbit, k;
  sacc_row_t   r;
  // Ordinary conversions: mode, channel, divider, count, result
  sacc_row_t   rows [7] = '{
    '{4'h1, 5'h05, 8'h00, 8'h00, 12'h2B5},
    '{4'h8, 5'h00, 8'h01, 8'h03, 12'h960},
    '{4'h6, 5'h1E, 8'h02, 8'h01, 12'hF30},
    '{4'hC, 5'h1F, 8'h00, 8'h00, 12'h4A8},
    '{4'hA, 5'h1F, 8'h00, 8'h00, 12'h4A0},
    '{4'h5, 5'h01, 8'h0B, 8'h00, 12'h0B5},
    '{4'h9, 5'h01, 8'h00, 8'hFF, 12'h0B5}};

  assign hready = hreadyout;

  sacc_ctrl DUT (
    .clk                  (clk),
    .rst_n                (rst_n),
    .hsel                 (hsel),
    .haddr                (haddr),
    .htrans               (htrans),
    .hwrite               (hwrite),
    .hsize                (hsize),
    .hwdata               (hwdata),
    .hready               (hready),
    .hreadyout            (hreadyout),
    .hresp                (hresp),
    .hrdata               (hrdata),
    .cmp_hi               (cmp_hi),
    .mux_channel          (mux_channel),
    .mux_src              (mux_src),
    .mux_quad             (mux_quad),
    .dac_code             (dac_code),
    .internal_temp_strobe (internal_temp_strobe),
    .adc_power_on         (adc_power_on),
    .busy                 (busy),
    .sampling             (sampling),
    .cal_active           (cal_active),
    .result_valid         (result_valid),
    .result               (result),
    .temp_kelvin          (temp_kelvin)
  );

  sacc_ana_model ANA (
    .clk                  (clk),
    .mux_channel          (mux_channel),
    .dac_code             (dac_code),
    .internal_temp_strobe (internal_temp_strobe),
    .adc_power_on         (adc_power_on),
    .cmp_hi               (cmp_hi)
  );

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Capture read data before the edge's own updates land
  always @(posedge clk) begin
    rd_smp <= hrdata;
  end

  // Watchdog: the longest run is under 20000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      $display("ERROR t=%0t watchdog expired", $time);
      tally_and_finish();
    end
  end

  // Compare one design value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Compare one cycle count
  task automatic chk_n(input int got, input int exp, input string what);
    checks_done++;
    if (got != exp) begin
      mismatches++;
      $display("ERROR t=%0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  // One single word transfer; only the watchdog ends a wait on hready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do begin
      @(posedge clk);
    end while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    do begin
      @(posedge clk);
    end while (hready !== 1'b1);
    #1;
    rq = rd_smp;
    chk(hresp, 1'b0, "hresp");
  endtask

  // Follow a conversion from its start edge, counting phase cycles
  task automatic run_conv(output int b, output int s, output int c);
    b = 0;
    s = 0;
    c = 0;
    #1;
    chk({busy, sampling, result_valid}, 3'b110, "start flags");
    while (busy === 1'b1 && b < 20000) begin
      b++;
      if (sampling === 1'b1) s++;
      if (cal_active === 1'b1) c++;
      @(posedge clk);
      #1;
    end
    chk(result_valid, 1'b1, "valid");
  endtask

  // Print counts and the verdict, then stop
  task tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_n  = 1'b0;
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values of every register and of an unmapped word
    for (i = 0; i <= 8'h40; i += 4) begin
      bus(1'b0, i[7:0], 32'h0, q);
      chk(q, 32'h0, "reset read");
    end
    chk(mux_src, SACC_SRC_CORE, "reset src");
    $display("test reset done");
    // Channel decode over all 32 codes
    for (i = 0; i < 32; i++) begin
      bus(1'b1, `SACC_OFS_CTRL, i, q);
      #1;
      chk(mux_channel, i, "channel");
      chk(mux_src, (i == 0) ? 0 : (i == 31) ? 4 : 1 + (i - 1) % 3, "src");
      chk(mux_quad, (i == 0 || i == 31) ? 0 : (i - 1) / 3, "quad");
    end
    $display("test channels done");
    // Conversion table
    for (i = 0; i < 7; i++) begin
      r = rows[i];
      bus(1'b1, `SACC_OFS_CTRL, {19'h0, r.ch == 5'h1F, r.mode, 3'h0, r.ch}, q);
      bus(1'b1, `SACC_OFS_TIME, {16'h0, r.sample_time_count, r.div}, q);
      bus(1'b1, `SACC_OFS_CMD, 32'h1, q);
      run_conv(nb, ns, nc);
      p = 4 * (1 + r.div);
      nbit = (r.mode[1:0] == 2'b01) ? 12 : (r.mode[1:0] == 2'b10) ? 8 : 10;
      chk_n(ns, (2 + r.sample_time_count) * p, "sample cycles");
      chk_n(nc, (r.mode[3] ? 0 : 2) * p, "cal cycles");
      chk_n(nb, ns + nbit * p + nc, "busy cycles");
      chk(result, r.exp, "result");
      chk(temp_kelvin, r.exp[11:2], "kelvin");
      chk(adc_power_on, r.mode[2], "power");
      chk(internal_temp_strobe, r.ch == 5'h1F, "strobe");
      bus(1'b0, `SACC_OFS_STAT, 32'h0, q);
      chk(q, 32'h4, "status");
      bus(1'b0, `SACC_OFS_TEMP, 32'h0, q);
      k = r.exp[11:2];
      chk(q[25:16], (k >= 5) ? k - 5 : 0, "corrected");
      chk(result, r.exp, "held");
      $display("test row %0d done", i);
    end
    // Second start while busy is ignored
    bus(1'b1, `SACC_OFS_CTRL, 32'h105, q);
    bus(1'b1, `SACC_OFS_TIME, 32'h0, q);
    bus(1'b1, `SACC_OFS_CMD, 32'h1, q);
    bus(1'b1, `SACC_OFS_CMD, 32'h1, q);
    run_conv(nb, ns, nc);
    chk_n(nb, 61, "refused start");
    chk(result, 12'h2B5, "refused result");
    $display("test refused start done");
    // Readback, write-only and unmapped places
    bus(1'b1, `SACC_OFS_CTRL, 32'hFFFFFFFF, q);
    bus(1'b1, `SACC_OFS_TIME, 32'hFFFFFFFF, q);
    bus(1'b1, 8'h40, 32'hFFFFFFFF, q);
    bus(1'b0, `SACC_OFS_CTRL, 32'h0, q);
    chk(q, 32'h00001F1F, "ctrl readback");
    bus(1'b0, `SACC_OFS_TIME, 32'h0, q);
    chk(q, 32'h0000FFFF, "time readback");
    bus(1'b0, `SACC_OFS_CMD, 32'h0, q);
    chk(q, 32'h0, "cmd read");
    bus(1'b0, 8'h40, 32'h0, q);
    chk(q, 32'h0, "unmapped read");
    $display("test registers done");
    // Reset in mid-conversion
    bus(1'b1, `SACC_OFS_CTRL, 32'h105, q);
    bus(1'b1, `SACC_OFS_TIME, 32'h0, q);
    bus(1'b1, `SACC_OFS_CMD, 32'h1, q);
    repeat (10) @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk({busy, sampling, cal_active, result_valid}, 4'h0, "reset flags");
    chk({result, dac_code, mux_channel, adc_power_on}, 30'h0, "reset outputs");
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule
